// ---- logic/thermal_sensor_register_set.sv ----
// Behaviour
// - nonzero selector high bits abort the frame
// - low selector bits pick one of four registers
// - selector persists; resets to zero
// - settings 8 bits, zero reset, bit7 read-only
// - settings fields: pd, mode, polarity, fault count
// - mode bit picks comparator or interrupt alarm
// - polarity zero drives alarm active low
// - reading 16-bit signed, refreshed per conversion
// - reading held during reads; buffer always loads
// - value in bits 15..7, lower bits zero
// - reading is zero until first conversion
// - upper trip point resets to 0x5000
// - lower trip point resets to 0x4b00
// - only top nine trip bits are compared
// - fault code gives 1, 2, 4, 6 faults
// - comparator alarm holds until below lower point
// - interrupt alarm clears on read, rearms below
// - power-down halts conversions, keeps bus alive
`timescale 1ns/1ns
`default_nettype none
module thermal_sensor_register_set (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial front end, byte level, on link_clk
  input wire logic link_clk,
  input wire logic frame_active,
  input wire logic byte_valid,
  input wire logic byte_is_read,
  input wire logic [7:0] byte_wdata,
  output logic byte_done,
  output logic [7:0] byte_rdata,
  // converter
  input wire logic conv_done,
  input wire logic [8:0] conv_result,
  output logic conv_enable,
  // open-drain alarm pin
  output logic alarm_output_o,
  output logic alarm_output_oe_n
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  link_evt_if evt ();
  logic [1:0] selector; // low selector bits
  logic [7:0] settings_reg;
  logic [15:0] reading; // measured reading
  logic [15:0] lower_trip_point;
  logic [15:0] upper_trip_point;
  logic [8:0] cmp_buf; // comparison buffer
  logic cmp_valid; // new value in the buffer
  logic frame_q; // frame level one cycle ago
  logic [1:0] wr_idx; // written byte number in the frame
  logic aborted; // frame terminated by a bad selector
  logic rd_half; // next read byte is the low byte
  logic read_busy; // a read is under way
  logic [7:0] trip_msb; // staged top byte of a trip write
  logic ans_toggle;
  logic [7:0] ans_data;
  thermal_regs_pkg::watch_t state;
  logic [2:0] fault_cnt;
  logic alarm_active;
  logic pd_q; // power-down bit one cycle ago

  wire frame_rise = evt.frame & ~frame_q;
  wire wr_ev = evt.ev & ~evt.ev_read & ~aborted;
  wire rd_ev = evt.ev & evt.ev_read;
  wire int_mode = settings_reg[thermal_regs_pkg::SET_MODE_BIT];
  wire alarm_level_select = settings_reg[thermal_regs_pkg::SET_POL_BIT];
  wire pd = settings_reg[thermal_regs_pkg::SET_PD_BIT];
  wire bad_sel = |(evt.ev_data & thermal_regs_pkg::SELECTOR_ZERO_MASK);
  wire [2:0] need = thermal_regs_pkg::fault_need(
    settings_reg[thermal_regs_pkg::SET_FT_HI_BIT:thermal_regs_pkg::SET_FT_LO_BIT]);
  wire hi_fault = thermal_regs_pkg::above(cmp_buf, upper_trip_point[15:7]);
  wire lo_fault = thermal_regs_pkg::above(lower_trip_point[15:7], cmp_buf);
  wire count_met = ({1'b0, fault_cnt} + 4'h1) >= {1'b0, need};

  assign evt.ans_toggle = ans_toggle;
  assign evt.ans_data = ans_data;

  // byte transport and clock crossing
  link_port u_link (
    .mclk(mclk),
    .arst_n(arst_n),
    .link_clk(link_clk),
    .frame_active(frame_active),
    .byte_valid(byte_valid),
    .byte_is_read(byte_is_read),
    .byte_wdata(byte_wdata),
    .byte_done(byte_done),
    .byte_rdata(byte_rdata),
    .evt(evt)
  );

  // ------------------------------------------------------------
  // frame sequencing
  // ------------------------------------------------------------
  // first written byte of a frame is the selector
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame_q <= 1'b0;
      wr_idx <= 2'h0;
      aborted <= 1'b0;
      read_busy <= 1'b0;
    end
    else
    begin
      frame_q <= evt.frame;
      if (frame_rise)
      begin
        wr_idx <= 2'h0;
        aborted <= 1'b0;
      end
      else if (wr_ev)
      begin
        if (wr_idx == 2'h0 && bad_sel)
          aborted <= 1'b1;
        if (wr_idx != 2'h3)
          wr_idx <= wr_idx + 2'h1;
      end
      // busy from the first byte request to the end of the frame
      if (rd_ev)
        read_busy <= 1'b1;
      else if (!evt.frame)
        read_busy <= 1'b0;
    end
  end

  // selector keeps its value across frames
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      selector <= thermal_regs_pkg::SELECTOR_RESET;
    else if (wr_ev && wr_idx == 2'h0 && !bad_sel)
      selector <= evt.ev_data[1:0];
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // settings take one byte; bit 7 is never stored
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      settings_reg <= thermal_regs_pkg::SETTINGS_RESET;
    else if (wr_ev && wr_idx == 2'h1 && selector == thermal_regs_pkg::SEL_SETTINGS)
      settings_reg <= {1'b0, evt.ev_data[6:0]};
  end

  // trip points take top byte then low byte, committed together
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trip_msb <= 8'h00;
      lower_trip_point <= thermal_regs_pkg::LOWER_RESET;
      upper_trip_point <= thermal_regs_pkg::UPPER_RESET;
    end
    else if (wr_ev)
    begin
      if (wr_idx == 2'h1)
        trip_msb <= evt.ev_data;
      else if (wr_idx == 2'h2 && selector == thermal_regs_pkg::SEL_LOWER)
        lower_trip_point <= {trip_msb, evt.ev_data};
      else if (wr_idx == 2'h2 && selector == thermal_regs_pkg::SEL_UPPER)
        upper_trip_point <= {trip_msb, evt.ev_data};
    end
  end

  // ------------------------------------------------------------
  // read answers
  // ------------------------------------------------------------
  // every event is answered; 16-bit registers go top byte first
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ans_toggle <= 1'b0;
      ans_data <= 8'h00;
      rd_half <= 1'b0;
    end
    else
    begin
      if (evt.ev)
        ans_toggle <= ~ans_toggle;
      if (frame_rise)
        rd_half <= 1'b0;
      else if (rd_ev)
      begin
        case (selector)
          thermal_regs_pkg::SEL_READING:
            ans_data <= rd_half ? reading[7:0] : reading[15:8];
          thermal_regs_pkg::SEL_SETTINGS:
            ans_data <= settings_reg;
          thermal_regs_pkg::SEL_LOWER:
            ans_data <= rd_half ? lower_trip_point[7:0] : lower_trip_point[15:8];
          default:
            ans_data <= rd_half ? upper_trip_point[7:0] : upper_trip_point[15:8];
        endcase
        if (selector != thermal_regs_pkg::SEL_SETTINGS)
          rd_half <= ~rd_half;
      end
    end
  end

  // ------------------------------------------------------------
  // conversion results
  // ------------------------------------------------------------
  // a result landing during a read is kept only for comparison,
  // so a master that never pauses never sees a fresh reading
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reading <= thermal_regs_pkg::READING_RESET;
      cmp_buf <= 9'h000;
      cmp_valid <= 1'b0;
      conv_enable <= 1'b0;
    end
    else
    begin
      cmp_valid <= conv_done;
      if (conv_done)
        cmp_buf <= conv_result;
      if (conv_done && !read_busy)
        reading <= {conv_result, 7'h00};
      // the converter finishes a running conversion on its own
      conv_enable <= ~pd;
    end
  end

  // ------------------------------------------------------------
  // alarm
  // ------------------------------------------------------------
  // watch high until the fault count is met, then watch low
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= thermal_regs_pkg::WATCH_HIGH;
      fault_cnt <= 3'h0;
      alarm_active <= 1'b0;
      pd_q <= 1'b0;
    end
    else
    begin
      pd_q <= pd;
      // clears first, so a set in the same cycle wins
      if (int_mode && (rd_ev || (pd && !pd_q)))
        alarm_active <= 1'b0;
      if (cmp_valid)
      begin
        case (state)
          thermal_regs_pkg::WATCH_HIGH:
            if (hi_fault)
            begin
              if (count_met)
              begin
                alarm_active <= 1'b1;
                state <= thermal_regs_pkg::WATCH_LOW;
                fault_cnt <= 3'h0;
              end
              else
                fault_cnt <= fault_cnt + 3'h1;
            end
            else
              fault_cnt <= 3'h0;
          thermal_regs_pkg::WATCH_LOW:
            if (lo_fault && !int_mode)
            begin
              alarm_active <= 1'b0;
              state <= thermal_regs_pkg::WATCH_HIGH;
              fault_cnt <= 3'h0;
            end
            else if (lo_fault)
            begin
              if (count_met)
              begin
                alarm_active <= 1'b1;
                state <= thermal_regs_pkg::WATCH_HIGH;
                fault_cnt <= 3'h0;
              end
              else
                fault_cnt <= fault_cnt + 3'h1;
            end
            else
              fault_cnt <= 3'h0;
          default:
            state <= thermal_regs_pkg::WATCH_HIGH;
        endcase
      end
    end
  end

  // open drain: pull low only when the wanted level is low
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      alarm_output_o <= 1'b0;
      alarm_output_oe_n <= 1'b1;
    end
    else
    begin
      alarm_output_o <= 1'b0;
      alarm_output_oe_n <= alarm_level_select ? alarm_active : ~alarm_active;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_sel_write;
    wr_ev && wr_idx == 2'h0;
  endsequence
  sequence s_set_read;
    rd_ev && selector == thermal_regs_pkg::SEL_SETTINGS;
  endsequence

  property p_bad_sel;
    s_sel_write and bad_sel |=> aborted && $stable(selector);
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("bad selector not refused");

  property p_sel_hold;
    !(evt.ev && !evt.ev_read) |=> $stable(selector);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selector changed alone");

  property p_set_read;
    s_set_read |=> ans_data == $past(settings_reg) && !ans_data[7];
  endproperty
  a_set_read: assert property (p_set_read) else $error("settings answer wrong");

  property p_ro_bit;
    !settings_reg[thermal_regs_pkg::SET_RO_BIT];
  endproperty
  a_ro_bit: assert property (p_ro_bit) else $error("settings bit 7 set");

  property p_read_hold;
    conv_done && read_busy |=> $stable(reading);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("reading moved in a read");

  property p_read_load;
    conv_done && !read_busy |=> reading[15:7] == $past(conv_result) && reading[6:0] == 7'h00;
  endproperty
  a_read_load: assert property (p_read_load) else $error("reading not loaded");

  property p_int_clear;
    rd_ev && int_mode && !cmp_valid |=> !alarm_active;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("alarm kept after read");

  property p_rise_cause;
    $rose(alarm_active) |-> $past(cmp_valid);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("alarm rose unprompted");

  property p_pin_level;
    alarm_active && $stable(alarm_active) && $stable(alarm_level_select)
      |=> alarm_output_oe_n == $past(alarm_level_select) && !alarm_output_o;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("alarm pin level wrong");

  property p_pd_halt;
    pd ##1 pd |-> !conv_enable;
  endproperty
  a_pd_halt: assert property (p_pd_halt) else $error("converter runs in power-down");
endmodule
`default_nettype wire

// ---- logic/thermal_regs_pkg.sv ----
`default_nettype none
package thermal_regs_pkg;
  // ------------------------------------------------------------
  // register selector codes
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_READING = 2'h0;
  localparam logic [1:0] SEL_SETTINGS = 2'h1;
  localparam logic [1:0] SEL_LOWER = 2'h2;
  localparam logic [1:0] SEL_UPPER = 2'h3;
  // selector bits that must stay zero
  localparam logic [7:0] SELECTOR_ZERO_MASK = 8'hfc;
  // ------------------------------------------------------------
  // settings field positions
  // ------------------------------------------------------------
  localparam int SET_PD_BIT = 0;
  localparam int SET_MODE_BIT = 1;
  localparam int SET_POL_BIT = 2;
  localparam int SET_FT_LO_BIT = 3;
  localparam int SET_FT_HI_BIT = 4;
  localparam int SET_RO_BIT = 7;
  // ------------------------------------------------------------
  // reset values and value layout
  // ------------------------------------------------------------
  localparam logic [1:0] SELECTOR_RESET = 2'h0;
  localparam logic [7:0] SETTINGS_RESET = 8'h00;
  localparam logic [15:0] READING_RESET = 16'h0000;
  localparam logic [15:0] LOWER_RESET = 16'h4b00;
  localparam logic [15:0] UPPER_RESET = 16'h5000;
  localparam int VALUE_LSB = 7;
  localparam int VALUE_W = 9;
  // consecutive faulting conversions per fault-count code
  localparam logic [2:0] FAULTS_CODE0 = 3'h1;
  localparam logic [2:0] FAULTS_CODE1 = 3'h2;
  localparam logic [2:0] FAULTS_CODE2 = 3'h4;
  localparam logic [2:0] FAULTS_CODE3 = 3'h6;
  // ------------------------------------------------------------
  // alarm watch states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {WATCH_HIGH = 2'b01, WATCH_LOW = 2'b10} watch_t;

  // fault-count code to number of consecutive faults
  function automatic logic [2:0] fault_need(input logic [1:0] code);
    case (code)
      2'h0: fault_need = FAULTS_CODE0;
      2'h1: fault_need = FAULTS_CODE1;
      2'h2: fault_need = FAULTS_CODE2;
      default: fault_need = FAULTS_CODE3;
    endcase
  endfunction

  // signed compare of two 9-bit values, a strictly above b
  function automatic logic above(input logic [8:0] a, input logic [8:0] b);
    above = $signed(a) > $signed(b);
  endfunction
endpackage
`default_nettype wire

// ---- logic/link_evt_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// byte events and answers, already moved onto mclk
interface link_evt_if;
  logic ev; // one-cycle pulse: a byte event
  logic ev_read; // event is a byte request
  logic [7:0] ev_data; // byte written by the master
  logic frame; // frame level, synchronised
  logic ans_toggle; // flips once per finished event
  logic [7:0] ans_data; // byte answered to a request
  modport port (output ev, ev_read, ev_data, frame, input ans_toggle, ans_data);
  modport core (input ev, ev_read, ev_data, frame, output ans_toggle, ans_data);
endinterface
`default_nettype wire

// ---- logic/link_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module link_port (
  // clocks and reset
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic link_clk,
  // link side
  input wire logic frame_active,
  input wire logic byte_valid,
  input wire logic byte_is_read,
  input wire logic [7:0] byte_wdata,
  output logic byte_done,
  output logic [7:0] byte_rdata,
  // core side
  link_evt_if.port evt
);
  // ------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------
  logic req_t; // flips once per captured byte event
  logic hold_read; // held until the core answers
  logic [7:0] hold_data;
  logic ack_s1, ack_s2, ack_s3; // answer toggle synchroniser

  // capture an event; the front end waits for byte_done first
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_t <= 1'b0;
      hold_read <= 1'b0;
      hold_data <= 8'h00;
    end
    else if (byte_valid)
    begin
      hold_read <= byte_is_read;
      hold_data <= byte_wdata;
      req_t <= ~req_t;
    end
  end

  // answer comes back as a toggle, data is stable by then
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      byte_done <= 1'b0;
      byte_rdata <= 8'h00;
    end
    else
    begin
      ack_s1 <= evt.ans_toggle;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      byte_done <= ack_s2 ^ ack_s3;
      if (ack_s2 ^ ack_s3)
        byte_rdata <= evt.ans_data;
    end
  end

  // ------------------------------------------------------------
  // mclk domain
  // ------------------------------------------------------------
  logic req_s1, req_s2, req_s3;
  logic fr_s1, fr_s2; // frame pin, asynchronous level
  logic ev_q, ev_read_q;
  logic [7:0] ev_data_q;

  // frame level is taken straight from the pin: the link clock
  // may stop at the end of a frame
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      fr_s1 <= 1'b0;
      fr_s2 <= 1'b0;
      ev_q <= 1'b0;
      ev_read_q <= 1'b0;
      ev_data_q <= 8'h00;
    end
    else
    begin
      req_s1 <= req_t;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      fr_s1 <= frame_active;
      fr_s2 <= fr_s1;
      ev_q <= req_s2 ^ req_s3;
      // held words settled two edges ago
      if (req_s2 ^ req_s3)
      begin
        ev_read_q <= hold_read;
        ev_data_q <= hold_data;
      end
    end
  end

  assign evt.ev = ev_q;
  assign evt.ev_read = ev_read_q;
  assign evt.ev_data = ev_data_q;
  assign evt.frame = fr_s2;
endmodule
`default_nettype wire

// ---- verification/link_master.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// byte-level bus master: frames, byte events, link clock
// ------------------------------------------------------------
module link_master (
  // link clock and frame
  output var logic link_clk,
  output var logic frame_active,
  // byte request
  output var logic byte_valid,
  output var logic byte_is_read,
  output var logic [7:0] byte_wdata,
  // byte answer
  input wire logic byte_done,
  input wire logic [7:0] byte_rdata
);
  logic run; // clock runs while set, stands still otherwise
  // idle bus at time zero
  initial
  begin
    link_clk = 1'b0;
    frame_active = 1'b0;
    byte_valid = 1'b0;
    byte_is_read = 1'b0;
    byte_wdata = 8'h00;
    run = 1'b1;
  end
  // link clock: a started high phase always completes; offset by 3 ns
  // so that its edges never meet an edge of the core clock
  initial
  begin
    #3;
    forever
    begin
      #16;
      if (run || link_clk)
        link_clk = ~link_clk;
    end
  end
  // free clocks, e.g. after reset release
  task automatic clocks(input int n);
    run = 1'b1;
    repeat (n) @(posedge link_clk);
    run = 1'b0;
  endtask
  // open a frame two link clocks before the first event
  task automatic frame_on();
    run = 1'b1;
    @(negedge link_clk);
    frame_active = 1'b1;
    @(negedge link_clk);
  endtask
  // close a frame; low time well over three core clocks
  task automatic frame_off();
    @(negedge link_clk);
    frame_active = 1'b0;
    @(negedge link_clk);
    run = 1'b0;
    #48;
  endtask
  // one byte event; released qualifiers carry inverted values
  task automatic xfer(input logic rd, input logic [7:0] wd, output logic [7:0] q,
                      output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge link_clk);
    byte_valid = 1'b1;
    byte_is_read = rd;
    byte_wdata = wd;
    @(negedge link_clk);
    byte_valid = 1'b0;
    byte_is_read = ~rd;
    byte_wdata = ~wd;
    // bounded wait: a lost answer shows as a failed handshake
    while (!ok && n < 16)
    begin
      // sampled mid-cycle, away from the edge that launches the answer
      @(negedge link_clk);
      ok = (byte_done === 1'b1);
      n++;
    end
    q = byte_rdata;
  endtask
endmodule
`default_nettype wire

// ---- verification/thermal_sensor_register_set_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module thermal_sensor_register_set_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic mclk, arst_n, conv_done, conv_enable; // core side
  logic [8:0] conv_result; // converter value
  logic link_clk, frame_active, byte_valid, byte_is_read, byte_done; // link
  logic [7:0] byte_wdata, byte_rdata, q1, q2; // link data
  logic alarm_output_o, alarm_output_oe_n; // alarm pin
  int err_total = 0;
  int comparisons = 0;
  int i, k;
  logic [15:0] v; // last value read
  logic [15:0] rst_val [4] = '{16'h0000, 16'h0000, 16'h4b00, 16'h5000};
  int need [4] = '{1, 2, 4, 6}; // faults per fault-count code
  // ------------------------------------------------------------
  // design and master
  // ------------------------------------------------------------
  thermal_sensor_register_set u_thermal_sensor_register_set (.mclk, .arst_n, .link_clk,
    .frame_active, .byte_valid, .byte_is_read, .byte_wdata, .byte_done, .byte_rdata,
    .conv_done, .conv_result, .conv_enable, .alarm_output_o, .alarm_output_oe_n);
  link_master u_link_master (.link_clk, .frame_active, .byte_valid, .byte_is_read,
    .byte_wdata, .byte_done, .byte_rdata);
  // core clock
  always #4 mclk = ~mclk;
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // alarm pin enable
  task automatic pin(input logic e);
    check(16'(alarm_output_oe_n), 16'(e));
  endtask
  // one byte event, its completion checked
  task automatic one(input logic rd, input logic [7:0] wd, output logic [7:0] q);
    logic ok;
    u_link_master.xfer(rd, wd, q, ok);
    check(16'(ok), 16'h0001);
  endtask
  // write frame: selector, then n data bytes, top byte first
  task automatic put(input logic [7:0] sel, input int n, input logic [15:0] d);
    logic [7:0] q;
    u_link_master.frame_on();
    one(1'b0, sel, q);
    if (n == 2)
      one(1'b0, d[15:8], q);
    if (n > 0)
      one(1'b0, d[7:0], q);
    u_link_master.frame_off();
  endtask
  // read frame: optional selector, then n bytes, top byte first
  task automatic get(input logic use_sel, input logic [7:0] sel, input int n,
                     output logic [15:0] d);
    logic [7:0] q;
    d = 16'h0000;
    u_link_master.frame_on();
    if (use_sel)
      one(1'b0, sel, q);
    repeat (n)
    begin
      one(1'b1, 8'h00, q);
      d = {d[7:0], q};
    end
    u_link_master.frame_off();
  endtask
  // one conversion, then time for the pin to follow
  task automatic conv(input logic [8:0] t);
    @(negedge mclk);
    conv_done = 1'b1;
    conv_result = t;
    @(negedge mclk);
    conv_done = 1'b0;
    conv_result = ~t;
    repeat (4) @(negedge mclk);
  endtask
  // conversion followed by a pin check
  task automatic conv_pin(input logic [8:0] t, input logic e);
    conv(t);
    pin(e);
  endtask
  // verdict, single exit
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    arst_n = 1'b0;
    conv_done = 1'b0;
    conv_result = 9'h000;
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    u_link_master.clocks(6);
    pin(1'b1);
    check(16'(conv_enable), 16'h0001);
    get(1'b0, 8'h00, 2, v);
    check(v, 16'h0000);
    // every selector code against its reset value
    for (i = 0; i < 4; i++)
    begin
      get(1'b1, 8'(i), (i == 1) ? 1 : 2, v);
      check(v, rst_val[i]);
    end
    get(1'b0, 8'h00, 2, v);
    check(v, 16'h5000);
    // all settings bits set, bit 7 among them
    put(8'h01, 1, 16'h00ff);
    get(1'b1, 8'h01, 1, v);
    check(v, 16'h007f);
    check(16'(conv_enable), 16'h0000);
    pin(1'b0);
    put(8'h01, 1, 16'h0000);
    check(16'(conv_enable), 16'h0001);
    // trip points, bad selectors, read-only reading
    put(8'h03, 2, 16'h1234);
    put(8'h02, 2, 16'habcd);
    put(8'h07, 2, 16'h5566);
    put(8'h83, 2, 16'h5566);
    put(8'h00, 2, 16'hffff);
    get(1'b1, 8'h03, 2, v);
    check(v, 16'h1234);
    get(1'b1, 8'h02, 2, v);
    check(v, 16'habcd);
    get(1'b1, 8'h00, 2, v);
    check(v, 16'h0000);
    // conversion results, positive and negative
    conv(9'h032);
    get(1'b0, 8'h00, 2, v);
    check(v, 16'h1900);
    conv(9'h1ce);
    get(1'b0, 8'h00, 2, v);
    check(v, 16'he700);
    // result arriving in mid-read is not stored
    u_link_master.frame_on();
    one(1'b1, 8'h00, q1);
    conv(9'h051);
    one(1'b1, 8'h00, q2);
    u_link_master.frame_off();
    check({q1, q2}, 16'he700);
    get(1'b0, 8'h00, 2, v);
    check(v, 16'he700);
    conv(9'h051);
    get(1'b0, 8'h00, 2, v);
    check(v, 16'h2880);
    // comparator alarm, all fault counts, low trip bits ignored
    put(8'h03, 2, 16'h197f);
    put(8'h02, 2, 16'h18ff);
    conv_pin(9'h030, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      put(8'h01, 1, 16'(i << 3));
      for (k = 1; k <= need[i]; k++)
        conv_pin(9'h033, k < need[i]);
      conv_pin(9'h031, 1'b0);
      conv_pin(9'h030, 1'b1);
    end
    // power-down keeps a comparator alarm
    put(8'h01, 1, 16'h0000);
    conv_pin(9'h033, 1'b0);
    put(8'h01, 1, 16'h0001);
    check(16'(conv_enable), 16'h0000);
    pin(1'b0);
    // active-high level
    put(8'h01, 1, 16'h0004);
    pin(1'b1);
    conv_pin(9'h030, 1'b0);
    conv_pin(9'h033, 1'b1);
    conv_pin(9'h030, 1'b0);
    // interrupt alarm: set, read clears, rearm below lower
    put(8'h01, 1, 16'h0002);
    pin(1'b1);
    conv_pin(9'h033, 1'b0);
    get(1'b1, 8'h01, 1, v);
    pin(1'b1);
    conv_pin(9'h033, 1'b1);
    conv_pin(9'h030, 1'b0);
    put(8'h01, 1, 16'h0003);
    pin(1'b1);
    check(16'(conv_enable), 16'h0000);
    put(8'h01, 1, 16'h0000);
    check(16'(conv_enable), 16'h0001);
    check(16'(alarm_output_o), 16'h0000);
    test_done();
  end
  // watchdog, well over ten times the expected run
  initial
  begin
    #400000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
